// ===== rtl/dif_top.sv
module dif_top
  import dif_pkg::*;
#(
  parameter int TICK_CYCLES = dif_pkg::RELAY_TICK_CYCLES
) (
  input  wire logic                            CLK_IN,
  input  wire logic                            RST_B_IN,
  input  wire logic [dif_pkg::NUM_IN-1:0]      DI_IN,
  input  wire logic [dif_pkg::NUM_IN*dif_pkg::FUNC_W-1:0] DI_FUNC_SEL_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       LOCAL_RUN_SOURCE_SELECT_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       REMOTE_RUN_SOURCE_SELECT_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       LOCAL_SPEED_REF_SOURCE_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       REMOTE_SPEED_REF_SOURCE_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       LOCAL_REMOTE_SOURCE_SELECT_IN,
  input  wire logic                            REMOTE_DEFAULT_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       CONTROL_TYPE_SELECT_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       FLYING_START_SETTING_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       PARAMETER_MEMORY_COMMAND_IN,
  input  wire logic                            PARAM_MEM_CMD_STB_IN,
  input  wire logic [dif_pkg::GAIN_W-1:0]      SPEED_REG_PROP_GAIN_IN,
  input  wire logic [dif_pkg::GAIN_W-1:0]      SPEED_REG_INT_GAIN_IN,
  input  wire logic                            PASSWORD_ALLOWS_IN,
  input  wire logic [dif_pkg::DLY_W-1:0]       RELAY2_ON_DELAY_IN,
  input  wire logic [dif_pkg::DLY_W-1:0]       RELAY2_OFF_DELAY_IN,
  input  wire logic [dif_pkg::DLY_W-1:0]       RELAY3_ON_DELAY_IN,
  input  wire logic [dif_pkg::DLY_W-1:0]       RELAY3_OFF_DELAY_IN,
  input  wire logic [dif_pkg::DOFN_W-1:0]      RELAY2_FUNCTION_SELECT_IN,
  input  wire logic [dif_pkg::DOFN_W-1:0]      RELAY3_FUNCTION_SELECT_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       TRACE_TRIGGER_SELECT_IN,
  input  wire logic [dif_pkg::CFG_W-1:0]       TRACE_STATE_IN,
  input  wire logic [dif_pkg::NUM_OUT-1:0]     DO_REQ_IN,
  output logic                                 REMOTE_OUT,
  output logic                                 RUN_REQ_OUT,
  output logic                                 GENERAL_ENABLE_OUT,
  output logic                                 FAST_STOP_OUT,
  output logic                                 POT_INC_OUT,
  output logic                                 POT_DEC_OUT,
  output logic                                 TORQUE_MODE_OUT,
  output logic [dif_pkg::GAIN_W-1:0]           SPEED_KP_OUT,
  output logic [dif_pkg::GAIN_W-1:0]           SPEED_KI_OUT,
  output logic                                 JOG_PLUS_OUT,
  output logic                                 JOG_MINUS_OUT,
  output logic                                 FLYING_START_EN_OUT,
  output logic [2:0]                           LOAD_USER_OUT,
  output logic                                 PARAM_WRITE_EN_OUT,
  output logic                                 MULTISPEED_EN_OUT,
  output logic [2:0]                           MULTISPEED_SEL_OUT,
  output logic                                 TRACE_TRIGGER_OUT,
  output logic                                 EXTERNAL_ALARM_INDICATION_OUT,
  output logic                                 AUTO_MODE_OUT,
  output logic [dif_pkg::NUM_IN-1:0]           PLC_INPUTS_OUT,
  output logic [dif_pkg::NUM_OUT-1:0]          DO_OUT,
  output logic [dif_pkg::NUM_OUT-1:0]          OUTPUT_STATE_WORD_OUT
);
  import dif_pkg::*;

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  // one bit per input that carries the given function code
  function automatic logic [NUM_IN-1:0] fmask(
    input logic [NUM_IN*FUNC_W-1:0] sel,
    input logic [FUNC_W-1:0]        code
  );
    logic [NUM_IN-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      m[i] = (sel[i*FUNC_W +: FUNC_W] == code);
    end
    return m;
  endfunction

  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] fall;

  dif_in_sync #(
    .W (NUM_IN)
  ) u_sync (
    .clk_in    (CLK_IN),
    .rst_b_in  (RST_B_IN),
    .pin_in    (DI_IN),
    .level_out (lvl),
    .rise_out  (rise),
    .fall_out  (fall)
  );

  logic [NUM_IN-1:0] m_run, m_ge, m_fs, m_fwd, m_rev, m_lr;
  logic [NUM_IN-1:0] m_inc, m_dec, m_ms, m_st, m_jp, m_jm;
  logic [NUM_IN-1:0] m_alm, m_plc, m_ma, m_fly, m_po;
  logic [NUM_IN-1:0] m_u12, m_u3, m_t2, m_t3, m_tr;

  assign m_run = fmask(DI_FUNC_SEL_IN, FN_RUN_STOP);
  assign m_ge  = fmask(DI_FUNC_SEL_IN, FN_GEN_EN);
  assign m_fs  = fmask(DI_FUNC_SEL_IN, FN_FAST_STOP);
  assign m_fwd = fmask(DI_FUNC_SEL_IN, FN_FWD_RUN);
  assign m_rev = fmask(DI_FUNC_SEL_IN, FN_REV_RUN);
  assign m_lr  = fmask(DI_FUNC_SEL_IN, FN_LOC_REM);
  assign m_inc = fmask(DI_FUNC_SEL_IN, FN_POT_INC);
  assign m_dec = fmask(DI_FUNC_SEL_IN, FN_POT_DEC);
  assign m_ms  = fmask(DI_FUNC_SEL_IN, FN_MULTISPD);
  assign m_st  = fmask(DI_FUNC_SEL_IN, FN_SPD_TRQ);
  assign m_jp  = fmask(DI_FUNC_SEL_IN, FN_JOG_PLUS);
  assign m_jm  = fmask(DI_FUNC_SEL_IN, FN_JOG_MINUS);
  assign m_alm = fmask(DI_FUNC_SEL_IN, FN_NO_ALARM);
  assign m_plc = fmask(DI_FUNC_SEL_IN, FN_PLC_USE);
  assign m_ma  = fmask(DI_FUNC_SEL_IN, FN_MAN_AUTO);
  assign m_fly = fmask(DI_FUNC_SEL_IN, FN_FLY_DIS);
  assign m_po  = fmask(DI_FUNC_SEL_IN, FN_PROG_OFF);
  assign m_u12 = fmask(DI_FUNC_SEL_IN, FN_LOAD_U12);
  assign m_u3  = fmask(DI_FUNC_SEL_IN, FN_LOAD_U3);
  assign m_t2  = fmask(DI_FUNC_SEL_IN, FN_RLY2_TMR);
  assign m_t3  = fmask(DI_FUNC_SEL_IN, FN_RLY3_TMR);
  assign m_tr  = fmask(DI_FUNC_SEL_IN, FN_TRACE);

  logic             remote_r, remote_nxt;
  logic [CFG_W-1:0] run_src;
  logic [CFG_W-1:0] spd_src;
  logic             ctrl_vec;
  logic             ctrl_jog;
  logic             fly_ok;
  logic             run_ready;
  logic             torque_nxt;

  // remote_r selects which command sources are live
  always_comb begin
    remote_nxt = REMOTE_DEFAULT_IN;
    if (LOCAL_REMOTE_SOURCE_SELECT_IN == LR_SRC_DI && |m_lr) begin
      remote_nxt = |(lvl & m_lr);
    end
  end

  assign run_src  = remote_r ? REMOTE_RUN_SOURCE_SELECT_IN
                             : LOCAL_RUN_SOURCE_SELECT_IN;
  assign spd_src  = remote_r ? REMOTE_SPEED_REF_SOURCE_IN
                             : LOCAL_SPEED_REF_SOURCE_IN;
  assign ctrl_vec = (CONTROL_TYPE_SELECT_IN == CTRL_SENSORLESS) ||
                    (CONTROL_TYPE_SELECT_IN == CTRL_ENCODER);
  assign ctrl_jog = ctrl_vec ||
                    (CONTROL_TYPE_SELECT_IN == CTRL_JOG_A) ||
                    (CONTROL_TYPE_SELECT_IN == CTRL_JOG_B);
  assign fly_ok   = (FLYING_START_SETTING_IN == FLY_SET_A) ||
                    (FLYING_START_SETTING_IN == FLY_SET_B);
  // the contacts outside must hold these closed for running
  assign run_ready = &(lvl | ~(m_ge | m_fs | m_fwd | m_rev));
  assign torque_nxt = ctrl_vec && |(lvl & m_st);

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      remote_r <= 1'b0;
    end else begin
      remote_r <= remote_nxt;
    end
  end

  // run and stop commands
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RUN_REQ_OUT        <= 1'b0;
      GENERAL_ENABLE_OUT <= 1'b0;
      FAST_STOP_OUT      <= 1'b0;
    end else begin
      RUN_REQ_OUT <= (run_src == RUN_SRC_DI) && |(lvl & m_run) &&
                     run_ready;
      GENERAL_ENABLE_OUT <= &(lvl | ~m_ge);
      FAST_STOP_OUT <= |(~lvl & m_fs);
    end
  end

  // speed reference modes
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      POT_INC_OUT        <= 1'b0;
      POT_DEC_OUT        <= 1'b0;
      MULTISPEED_EN_OUT  <= 1'b0;
      MULTISPEED_SEL_OUT <= 3'h0;
      AUTO_MODE_OUT      <= 1'b0;
      JOG_PLUS_OUT       <= 1'b0;
      JOG_MINUS_OUT      <= 1'b0;
    end else begin
      POT_INC_OUT <= (spd_src == SPD_SRC_POT) && |(lvl & m_inc);
      POT_DEC_OUT <= (spd_src == SPD_SRC_POT) && |(~lvl & m_dec);
      MULTISPEED_EN_OUT <= (spd_src == SPD_SRC_MULTI) &&
        |m_ms[MS_IDX_LAST:MS_IDX_FIRST];
      MULTISPEED_SEL_OUT <= (spd_src == SPD_SRC_MULTI) ?
        (lvl[MS_IDX_LAST:MS_IDX_FIRST] & m_ms[MS_IDX_LAST:MS_IDX_FIRST])
        : 3'h0;
      AUTO_MODE_OUT <= |(lvl & m_ma);
      JOG_PLUS_OUT  <= ctrl_jog && |(lvl & m_jp);
      JOG_MINUS_OUT <= ctrl_jog && |(lvl & m_jm);
    end
  end

  // regulator gains follow the speed/torque selection
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      TORQUE_MODE_OUT <= 1'b0;
      SPEED_KP_OUT    <= GAIN_ZERO;
      SPEED_KI_OUT    <= GAIN_ZERO;
    end else begin
      TORQUE_MODE_OUT <= torque_nxt;
      if (torque_nxt) begin
        SPEED_KP_OUT <= GAIN_UNITY;
        SPEED_KI_OUT <= GAIN_ZERO;
      end else begin
        SPEED_KP_OUT <= SPEED_REG_PROP_GAIN_IN;
        SPEED_KI_OUT <= SPEED_REG_INT_GAIN_IN;
      end
    end
  end

  // status indications and protection
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      FLYING_START_EN_OUT           <= 1'b0;
      PARAM_WRITE_EN_OUT            <= 1'b0;
      EXTERNAL_ALARM_INDICATION_OUT <= 1'b0;
      PLC_INPUTS_OUT                <= '0;
      REMOTE_OUT                    <= 1'b0;
    end else begin
      if (CONTROL_TYPE_SELECT_IN != CTRL_ENCODER) begin
        FLYING_START_EN_OUT <= fly_ok && !(|(lvl & m_fly));
      end else begin
        FLYING_START_EN_OUT <= fly_ok;
      end
      PARAM_WRITE_EN_OUT <= !(|(lvl & m_po)) && PASSWORD_ALLOWS_IN;
      // alarm only: nothing here touches the run path
      EXTERNAL_ALARM_INDICATION_OUT <= |(~lvl & m_alm);
      PLC_INPUTS_OUT <= lvl & m_plc;
      REMOTE_OUT     <= remote_r;
    end
  end

  // a memory may only be loaded once it has been saved
  logic [2:0] saved_r;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      saved_r <= 3'h0;
    end else if (PARAM_MEM_CMD_STB_IN) begin
      if (PARAMETER_MEMORY_COMMAND_IN == MEM_SAVE_1) begin
        saved_r[0] <= 1'b1;
      end
      if (PARAMETER_MEMORY_COMMAND_IN == MEM_SAVE_2) begin
        saved_r[1] <= 1'b1;
      end
      if (PARAMETER_MEMORY_COMMAND_IN == MEM_SAVE_3) begin
        saved_r[2] <= 1'b1;
      end
    end
  end

  // edge-driven pulses
  logic trace_cond;
  logic trace_cond_r;

  assign trace_cond = |(lvl & m_tr) &&
                      (TRACE_TRIGGER_SELECT_IN == TRACE_SEL_DI) &&
                      (TRACE_STATE_IN == TRACE_WAITING);

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      LOAD_USER_OUT     <= 3'h0;
      TRACE_TRIGGER_OUT <= 1'b0;
      trace_cond_r      <= 1'b0;
    end else begin
      LOAD_USER_OUT[0] <= saved_r[0] && |(rise & m_u12);
      LOAD_USER_OUT[1] <= saved_r[1] && |(fall & m_u12);
      LOAD_USER_OUT[2] <= saved_r[2] && |(rise & m_u3);
      trace_cond_r      <= trace_cond;
      // one trigger per time the condition becomes true
      TRACE_TRIGGER_OUT <= trace_cond && !trace_cond_r;
    end
  end

  // shared millisecond tick for both relay timers
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick;

  assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  logic tmr2_en, tmr3_en;
  logic rly2_tmr, rly3_tmr;

  assign tmr2_en = (RELAY2_FUNCTION_SELECT_IN == DO_FN_TIMER);
  assign tmr3_en = (RELAY3_FUNCTION_SELECT_IN == DO_FN_TIMER);

  dif_relay_timer #(
    .DW (DLY_W)
  ) u_tmr2 (
    .clk_in       (CLK_IN),
    .rst_b_in     (RST_B_IN),
    .enable_in    (tmr2_en),
    .level_in     (|(lvl & m_t2)),
    .tick_in      (tick),
    .on_delay_in  (RELAY2_ON_DELAY_IN),
    .off_delay_in (RELAY2_OFF_DELAY_IN),
    .relay_out    (rly2_tmr)
  );

  dif_relay_timer #(
    .DW (DLY_W)
  ) u_tmr3 (
    .clk_in       (CLK_IN),
    .rst_b_in     (RST_B_IN),
    .enable_in    (tmr3_en),
    .level_in     (|(lvl & m_t3)),
    .tick_in      (tick),
    .on_delay_in  (RELAY3_ON_DELAY_IN),
    .off_delay_in (RELAY3_OFF_DELAY_IN),
    .relay_out    (rly3_tmr)
  );

  logic [NUM_OUT-1:0] do_nxt;

  always_comb begin
    do_nxt    = DO_REQ_IN;
    do_nxt[1] = tmr2_en ? rly2_tmr : DO_REQ_IN[1];
    do_nxt[2] = tmr3_en ? rly3_tmr : DO_REQ_IN[2];
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DO_OUT <= '0;
    end else begin
      DO_OUT <= do_nxt;
    end
  end

  assign OUTPUT_STATE_WORD_OUT = DO_OUT;
endmodule // dif_top

// ===== pkg/dif_pkg.sv
// Functional notes
// - run/stop works only with source 1
// - fast stop uses zero deceleration ramp
// - pot increase high, decrease low, source 7
// - local low, remote high, selector 4
// - speed/torque honoured for control 3 or 4
// - torque: proportional gain 1.00, no integral
// - speed: configured gains restored
// - jog plus/minus for control 3,4,6,7
// - flying start disable high, re-enable 1/2; control 4 ignores the input
// - rise loads memory 1, fall memory 2
// - rise loads memory 3 if saved
// - programming off blocks all parameter changes; here it only clears PARAM_WRITE_EN_OUT, memory loads still pass
// - relay timer on/off delays by edges
// - short pulse resets timer, relay unchanged
// - relay timer needs output function 29
// - multispeed code 13 needs source 8
// - trace trigger: high, select 6, waiting
// - low input raises external alarm only
// - manual low uses reference, high uses PID
// - PLC-use input causes no drive action
// - status word bit0 output1 to bit4 output5
// - per-input function code 0 to 31
package dif_pkg;
  localparam int NUM_IN    = 8;
  localparam int NUM_OUT   = 5;
  localparam int FUNC_W    = 5;
  localparam int CFG_W     = 5;
  localparam int DOFN_W    = 6;
  localparam int GAIN_W    = 16;
  localparam int DLY_W     = 16;

  localparam logic [FUNC_W-1:0] FN_RUN_STOP  = 5'h01;
  localparam logic [FUNC_W-1:0] FN_GEN_EN    = 5'h02;
  localparam logic [FUNC_W-1:0] FN_FAST_STOP = 5'h03;
  localparam logic [FUNC_W-1:0] FN_FWD_RUN   = 5'h04;
  localparam logic [FUNC_W-1:0] FN_REV_RUN   = 5'h05;
  localparam logic [FUNC_W-1:0] FN_LOC_REM   = 5'h09;
  localparam logic [FUNC_W-1:0] FN_POT_INC   = 5'h0b;
  localparam logic [FUNC_W-1:0] FN_POT_DEC   = 5'h0c;
  localparam logic [FUNC_W-1:0] FN_MULTISPD  = 5'h0d;
  localparam logic [FUNC_W-1:0] FN_SPD_TRQ   = 5'h0f;
  localparam logic [FUNC_W-1:0] FN_JOG_PLUS  = 5'h10;
  localparam logic [FUNC_W-1:0] FN_JOG_MINUS = 5'h11;
  localparam logic [FUNC_W-1:0] FN_NO_ALARM  = 5'h12;
  localparam logic [FUNC_W-1:0] FN_PLC_USE   = 5'h15;
  localparam logic [FUNC_W-1:0] FN_MAN_AUTO  = 5'h16;
  localparam logic [FUNC_W-1:0] FN_FLY_DIS   = 5'h18;
  localparam logic [FUNC_W-1:0] FN_PROG_OFF  = 5'h1a;
  localparam logic [FUNC_W-1:0] FN_LOAD_U12  = 5'h1b;
  localparam logic [FUNC_W-1:0] FN_LOAD_U3   = 5'h1c;
  localparam logic [FUNC_W-1:0] FN_RLY2_TMR  = 5'h1d;
  localparam logic [FUNC_W-1:0] FN_RLY3_TMR  = 5'h1e;
  localparam logic [FUNC_W-1:0] FN_TRACE     = 5'h1f;

  localparam logic [CFG_W-1:0] RUN_SRC_DI     = 5'h01;
  localparam logic [CFG_W-1:0] SPD_SRC_POT    = 5'h07;
  localparam logic [CFG_W-1:0] SPD_SRC_MULTI  = 5'h08;
  localparam logic [CFG_W-1:0] LR_SRC_DI      = 5'h04;
  localparam logic [CFG_W-1:0] CTRL_SENSORLESS = 5'h03;
  localparam logic [CFG_W-1:0] CTRL_ENCODER   = 5'h04;
  localparam logic [CFG_W-1:0] CTRL_JOG_A     = 5'h06;
  localparam logic [CFG_W-1:0] CTRL_JOG_B     = 5'h07;
  localparam logic [CFG_W-1:0] FLY_SET_A      = 5'h01;
  localparam logic [CFG_W-1:0] FLY_SET_B      = 5'h02;
  localparam logic [CFG_W-1:0] MEM_SAVE_1     = 5'h0a;
  localparam logic [CFG_W-1:0] MEM_SAVE_2     = 5'h0b;
  localparam logic [CFG_W-1:0] MEM_SAVE_3     = 5'h0c;
  localparam logic [CFG_W-1:0] TRACE_SEL_DI   = 5'h06;
  localparam logic [CFG_W-1:0] TRACE_WAITING  = 5'h01;
  localparam logic [DOFN_W-1:0] DO_FN_TIMER   = 6'h1d;

  // gain scaled by 100, so 1.00 reads as 100
  localparam logic [GAIN_W-1:0] GAIN_UNITY    = 16'h0064;
  localparam logic [GAIN_W-1:0] GAIN_ZERO     = 16'h0000;

  localparam int MS_IDX_FIRST = 3;
  localparam int MS_IDX_LAST  = 5;

  // relay delays count in 1 ms ticks
  localparam int CLK_PERIOD_NS    = 20;
  localparam int RELAY_TICK_NS    = 1000000;
  localparam int RELAY_TICK_CYCLES = RELAY_TICK_NS / CLK_PERIOD_NS;
endpackage

// ===== rtl/dif_in_sync.sv
module dif_in_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // meta_r feeds sync_r only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out  = sync_r & ~prev_r;
  assign fall_out  = ~sync_r & prev_r;
endmodule // dif_in_sync

// ===== rtl/dif_relay_timer.sv
module dif_relay_timer #(
  parameter int DW = 16
) (
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          enable_in,
  input  wire logic          level_in,
  input  wire logic          tick_in,
  input  wire logic [DW-1:0] on_delay_in,
  input  wire logic [DW-1:0] off_delay_in,
  output logic               relay_out
);
  typedef enum logic {TMR_IDLE, TMR_WAIT} dif_tmr_e;
  dif_tmr_e        state_r;
  logic [DW-1:0]   cnt_r;
  logic            relay_r;
  logic [DW-1:0]   dly;

  assign dly = level_in ? on_delay_in : off_delay_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= TMR_IDLE;
      cnt_r   <= '0;
      relay_r <= 1'b0;
    end else if (!enable_in) begin
      state_r <= TMR_IDLE;
      cnt_r   <= '0;
      relay_r <= 1'b0;
    end else begin
      unique case (state_r)
        TMR_IDLE: begin
          cnt_r <= '0;
          if (level_in != relay_r) begin
            state_r <= TMR_WAIT;
          end
        end
        TMR_WAIT: begin
          if (level_in == relay_r) begin
            state_r <= TMR_IDLE;
            cnt_r   <= '0;
          end else if (cnt_r >= dly) begin
            relay_r <= level_in;
            state_r <= TMR_IDLE;
          end else if (tick_in) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  assign relay_out = relay_r;
endmodule // dif_relay_timer

// ===== verification/dif_top_sva.sv
module dif_top_sva
  import dif_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                        CLK_IN,
  input wire logic                        RST_B_IN,
  input wire logic                        PASSWORD_ALLOWS_IN,
  input wire logic [dif_pkg::CFG_W-1:0]   CONTROL_TYPE_SELECT_IN,
  input wire logic [dif_pkg::GAIN_W-1:0]  SPEED_REG_PROP_GAIN_IN,
  input wire logic [dif_pkg::GAIN_W-1:0]  SPEED_REG_INT_GAIN_IN,
  input wire logic [dif_pkg::NUM_OUT-1:0] DO_REQ_IN,
  input wire logic                        TORQUE_MODE_OUT,
  input wire logic [dif_pkg::GAIN_W-1:0]  SPEED_KP_OUT,
  input wire logic [dif_pkg::GAIN_W-1:0]  SPEED_KI_OUT,
  input wire logic                        JOG_PLUS_OUT,
  input wire logic [2:0]                  LOAD_USER_OUT,
  input wire logic                        PARAM_WRITE_EN_OUT,
  input wire logic                        TRACE_TRIGGER_OUT,
  input wire logic [dif_pkg::NUM_OUT-1:0] DO_OUT,
  input wire logic [dif_pkg::NUM_OUT-1:0] OUTPUT_STATE_WORD_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  logic [1:0] up_r;
  // up_r holds off the guarded checks until the fourth edge after release
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  sequence s_load_idle;
    LOAD_USER_OUT == 3'h0;
  endsequence
  a_word_mirror: assert property (OUTPUT_STATE_WORD_OUT == DO_OUT)
    else $error("status word differs from outputs");
  a_req_pass: assert property (up_r == 2'h3 |->
    (DO_OUT & 5'h19) == ($past(DO_REQ_IN) & 5'h19))
    else $error("plain output does not follow request");
  a_prog_lock: assert property (up_r == 2'h3 &&
    !$past(PASSWORD_ALLOWS_IN) |-> !PARAM_WRITE_EN_OUT)
    else $error("write allowed without password");
  a_torque_gain: assert property (TORQUE_MODE_OUT |->
    SPEED_KP_OUT == GAIN_UNITY && SPEED_KI_OUT == GAIN_ZERO)
    else $error("torque gains wrong");
  a_speed_gain: assert property (up_r == 2'h3 && !TORQUE_MODE_OUT &&
    !$past(TORQUE_MODE_OUT) |-> SPEED_KP_OUT == $past(SPEED_REG_PROP_GAIN_IN)
    && SPEED_KI_OUT == $past(SPEED_REG_INT_GAIN_IN))
    else $error("speed gains not restored");
  a_torque_ctrl: assert property (TORQUE_MODE_OUT |->
    $past(CONTROL_TYPE_SELECT_IN) inside {5'h03, 5'h04})
    else $error("torque mode with wrong control type");
  a_jog_ctrl: assert property (JOG_PLUS_OUT |->
    $past(CONTROL_TYPE_SELECT_IN) inside {5'h03, 5'h04, 5'h06, 5'h07})
    else $error("jog with wrong control type");
  a_load_pulse: assert property (LOAD_USER_OUT != 3'h0 |->
    $onehot(LOAD_USER_OUT) ##1 s_load_idle)
    else $error("load pulse malformed");
  a_trace_pulse: assert property (TRACE_TRIGGER_OUT |=>
    !TRACE_TRIGGER_OUT)
    else $error("trace pulse too long");
endmodule // dif_top_sva

bind dif_top dif_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
  .PASSWORD_ALLOWS_IN(PASSWORD_ALLOWS_IN),
  .CONTROL_TYPE_SELECT_IN(CONTROL_TYPE_SELECT_IN),
  .SPEED_REG_PROP_GAIN_IN(SPEED_REG_PROP_GAIN_IN),
  .SPEED_REG_INT_GAIN_IN(SPEED_REG_INT_GAIN_IN), .DO_REQ_IN(DO_REQ_IN),
  .TORQUE_MODE_OUT(TORQUE_MODE_OUT), .SPEED_KP_OUT(SPEED_KP_OUT),
  .SPEED_KI_OUT(SPEED_KI_OUT), .JOG_PLUS_OUT(JOG_PLUS_OUT),
  .LOAD_USER_OUT(LOAD_USER_OUT), .PARAM_WRITE_EN_OUT(PARAM_WRITE_EN_OUT),
  .TRACE_TRIGGER_OUT(TRACE_TRIGGER_OUT), .DO_OUT(DO_OUT),
  .OUTPUT_STATE_WORD_OUT(OUTPUT_STATE_WORD_OUT));

// ===== verification/dif_contacts.sv
module dif_contacts (
  input  wire logic       clk_in,
  input  wire logic [7:0] want_in,
  input  wire logic [7:0] hold_in,
  input  wire logic [4:0] relay_in,
  output logic      [4:0] coil_out
  ,output logic     [7:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // enable, stop and run contacts stay closed through the hold mask
  assign pin_out = want_in | hold_in;
  // coils lag the drive by a cycle, like a real armature
  always @(posedge clk_in) coil_out <= relay_in;
endmodule // dif_contacts

// ===== verification/test_drive_digital_input_functions.sv
module test_drive_digital_input_functions;
  timeunit 1ns;
  timeprecision 1ps;
  import dif_pkg::*;
  logic clk = 0, rst_b = 0, mstb = 0, pw = 1, rdef = 0, trg;
  logic [7:0] want = 0, di, plc;
  logic [39:0] fsel = 0;
  logic [4:0] lrsel = 4, ctrl = 3, fly = 1, mcmd = 0, tst = 1, tsel = 6;
  logic [4:0] run = 1, spd = 7, doreq = 0, osw, dout, coil;
  logic [15:0] kp = 16'h0123, ki = 16'h0045, ksp, kip;
  logic [15:0] d_on = 16'h0003, d_off = 16'h0002;
  logic [5:0] r2f = 0;
  logic [2:0] ld;
  logic [9:0] lv;
  logic [3:0] notes[$];
  int n_errors = 0, samples_checked = 0, seed = 32'h3eee1a6e, cnt;
  logic [4:0] codes[10] = '{5'h09, 5'h03, 5'h0b, 5'h0c, 5'h0f, 5'h10,
                            5'h18, 5'h1a, 5'h12, 5'h16};
  localparam logic [9:0] HI = 10'b10_0011_0101;
  dif_contacts u_ct (.clk_in(clk), .want_in(want), .hold_in(8'h00),
    .relay_in(dout), .coil_out(coil), .pin_out(di));
  dif_top #(.TICK_CYCLES(4)) u_dut (.CLK_IN(clk), .RST_B_IN(rst_b),
    .DI_IN(di), .DI_FUNC_SEL_IN(fsel), .LOCAL_RUN_SOURCE_SELECT_IN(run),
    .REMOTE_RUN_SOURCE_SELECT_IN(run), .LOCAL_SPEED_REF_SOURCE_IN(spd),
    .REMOTE_SPEED_REF_SOURCE_IN(spd), .LOCAL_REMOTE_SOURCE_SELECT_IN(lrsel),
    .REMOTE_DEFAULT_IN(rdef), .CONTROL_TYPE_SELECT_IN(ctrl),
    .FLYING_START_SETTING_IN(fly), .PARAMETER_MEMORY_COMMAND_IN(mcmd),
    .PARAM_MEM_CMD_STB_IN(mstb), .SPEED_REG_PROP_GAIN_IN(kp),
    .SPEED_REG_INT_GAIN_IN(ki), .PASSWORD_ALLOWS_IN(pw),
    .RELAY2_ON_DELAY_IN(d_on), .RELAY2_OFF_DELAY_IN(d_off),
    .RELAY3_ON_DELAY_IN(d_on), .RELAY3_OFF_DELAY_IN(d_off),
    .RELAY2_FUNCTION_SELECT_IN(r2f), .RELAY3_FUNCTION_SELECT_IN(r2f),
    .TRACE_TRIGGER_SELECT_IN(tsel), .TRACE_STATE_IN(tst), .DO_REQ_IN(doreq),
    .REMOTE_OUT(lv[0]), .RUN_REQ_OUT(), .GENERAL_ENABLE_OUT(),
    .FAST_STOP_OUT(lv[1]), .POT_INC_OUT(lv[2]), .POT_DEC_OUT(lv[3]),
    .TORQUE_MODE_OUT(lv[4]), .SPEED_KP_OUT(ksp), .SPEED_KI_OUT(kip),
    .JOG_PLUS_OUT(lv[5]), .JOG_MINUS_OUT(), .FLYING_START_EN_OUT(lv[6]),
    .LOAD_USER_OUT(ld), .PARAM_WRITE_EN_OUT(lv[7]), .MULTISPEED_EN_OUT(),
    .MULTISPEED_SEL_OUT(), .TRACE_TRIGGER_OUT(trg),
    .EXTERNAL_ALARM_INDICATION_OUT(lv[8]), .AUTO_MODE_OUT(lv[9]),
    .PLC_INPUTS_OUT(plc), .DO_OUT(dout), .OUTPUT_STATE_WORD_OUT(osw));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stp(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_coil(input logic v);
    cnt = 0;
    while (coil[1] !== v) begin
      stp(1);
      cnt++;
      if (cnt > 80) begin
        n_errors++;
        $display("BAD at %0t: relay wait ran out", $time);
        end_of_test();
      end
    end
  endtask
  // pulses are matched against notes left by the driver; none is unexpected
  always @(negedge clk) begin
    if ({trg, ld} !== 4'h0) begin
      if (notes.size() == 0) chk({trg, ld}, 16'h0);
      else chk({trg, ld}, notes.pop_front());
    end
  end
  initial begin
    stp(4);
    rst_b = 1;
    for (int i = 0; i < 10; i++) begin
      fsel[4:0] = codes[i];
      for (int v = 1; v >= 0; v--) begin
        want[0] = v[0];
        stp(7);
        chk(lv[i], v[0] ? HI[i] : !HI[i]);
      end
    end
    $display("level functions done");
    fsel[14:0] = {FN_LOC_REM, FN_JOG_PLUS, FN_SPD_TRQ};
    want[2:0] = 3'b111;
    for (int c = 0; c < 8; c++) begin
      ctrl = c[4:0];
      kp = 16'($random(seed));
      ki = 16'($random(seed));
      stp(6);
      chk(lv[4], c == 3 || c == 4);
      chk(lv[5], c inside {3, 4, 6, 7});
      chk(ksp, (c == 3 || c == 4) ? GAIN_UNITY : kp);
      chk(kip, (c == 3 || c == 4) ? GAIN_ZERO : ki);
    end
    lrsel = 0;
    for (int r = 1; r >= 0; r--) begin
      rdef = r[0];
      pw = r[0];
      stp(6);
      chk(lv[0], r[0]);
      chk(lv[7], r[0]);
    end
    lrsel = 4;
    pw = 1;
    $display("mode gating done");
    for (int i = 0; i < 8; i++) fsel[5*i +: 5] = FN_PLC_USE;
    for (int i = 0; i < 6; i++) begin
      want = 8'($random(seed));
      doreq = 5'($random(seed));
      stp(5);
      chk(plc, want);
      chk(lv, 10'h0c0);
      chk(osw & 5'h19, doreq & 5'h19);
    end
    $display("plc and outputs done");
    fsel = 0;
    fsel[19:10] = {FN_LOAD_U3, FN_LOAD_U12};
    want = 0;
    doreq = 0;
    stp(5);
    // toggles before any save must not load
    want[3:2] = 2'b11;
    stp(5);
    want[3:2] = 2'b00;
    for (int m = 10; m < 13; m++) begin
      mcmd = m[4:0];
      mstb = 1;
      stp(1);
      mstb = 0;
      stp(4);
    end
    for (int k = 0; k < 3; k++) begin
      notes.push_back(4'h1 << k);
      want[2 + k / 2] = (k != 1);
      stp(5);
    end
    fsel[24:20] = FN_TRACE;
    notes.push_back(4'h8);
    want[4] = 1;
    stp(6);
    for (int k = 0; k < 2; k++) begin
      want[4] = 0;
      tst = k ? 5'h01 : 5'h00;
      tsel = k ? 5'h05 : 5'h06;
      stp(4);
      want[4] = 1;
      stp(6);
    end
    chk(16'(notes.size()), 16'h0);
    $display("pulse functions done");
    fsel[29:25] = FN_RLY2_TMR;
    r2f = DO_FN_TIMER;
    stp(10);
    want[5] = 1;
    wait_coil(1);
    chk(cnt >= 8, 1);
    // a low blip shorter than the off delay
    want[5] = 0;
    stp(2);
    want[5] = 1;
    stp(30);
    chk({coil[1], osw[1]}, 2'b11);
    want[5] = 0;
    wait_coil(0);
    chk(cnt >= 4, 1);
    r2f = 0;
    want[5] = 1;
    stp(40);
    chk(dout[1], 0);
    $display("relay timer done");
    end_of_test();
  end
endmodule // test_drive_digital_input_functions
